//--- rtl/ddsc_pkg.sv
// package of constants for the dual converter serial command port
// assumes a 24-bit msb-first frame clocked on the falling link clock edge
package ddsc_pkg;
  localparam int unsigned FRAME_BITS    = 24;
  localparam int unsigned SAMPLE_W      = 16;
  localparam int unsigned CMD_W         = FRAME_BITS;
  localparam int unsigned FIFO_DEPTH    = 4;
  localparam int unsigned POS_LOAD_B    = 21;
  localparam int unsigned POS_LOAD_A    = 20;
  localparam int unsigned POS_BUF_SEL   = 18;
  localparam int unsigned POS_MODE_HIGH = 17;
  localparam int unsigned POS_MODE_LOW  = 16;
  localparam logic [4:0]  BIT_CNT_LAST  = 5'h17;
  localparam logic [15:0] SAMPLE_RESET  = 16'h0000;
  localparam logic [1:0]  MODE_RESET    = 2'h0;

  typedef enum logic [1:0] {
    DDSC_MODE_NORMAL = 2'b00,
    DDSC_MODE_1K     = 2'b01,
    DDSC_MODE_100K   = 2'b10,
    DDSC_MODE_HIZ    = 2'b11
  } ddsc_mode_e;
endpackage

//--- rtl/ddsc_fifo.sv
// small valid/ready fifo for completed frames
// assumes one clock; width and depth are parameters
`timescale 1ns/100ps
module ddsc_fifo #(
  parameter int unsigned WIDTH = 24,
  parameter int unsigned DEPTH = 4
) (
  // clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             rst_n_i,
  // fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  wire              push_w = in_valid_i & in_ready_o;
  wire              pop_w  = out_valid_o & out_ready_i;

  // count is one bit wider than the pointers so that full is distinct from empty
  assign in_ready_o  = (count_r != (AW+1)'(DEPTH));
  assign out_valid_o = (count_r != '0);
  assign out_data_o  = mem_r[rd_ptr_r];

  always_ff @(posedge sys_clk_i) begin
    if (push_w) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push_w) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop_w) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_r + {{AW{1'b0}}, push_w} - {{AW{1'b0}}, pop_w};
    end
  end
endmodule

//--- rtl/ddsc_port.sv
// serial command port of a dual 16-bit converter, with channel registers
// assumes link_clk_i runs only inside frames; sys_clk_i is free running
`timescale 1ns/100ps
module ddsc_port (
  // system clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  // serial link
  input  wire logic        link_clk_i,
  input  wire logic        frame_sel_n_i,
  input  wire logic        link_data_i,
  // channel a state
  output logic [15:0]      chan_a_code_o,
  output logic [1:0]       chan_a_mode_o,
  // channel b state
  output logic [15:0]      chan_b_code_o,
  output logic [1:0]       chan_b_mode_o,
  // buffer contents and status
  output logic [15:0]      buf_a_code_o,
  output logic [15:0]      buf_b_code_o,
  output logic             frame_done_o,
  output logic             frame_drop_o
);
  // ---------------- link domain ----------------
  // shift register and bit counter on the falling link edge
  logic [22:0] shift_r;
  logic [4:0]  bit_cnt_r;
  logic [23:0] frame_word_r;
  logic        frame_tgl_r;
  wire  [23:0] full_word_w = {shift_r, link_data_i};

  // a raised select resets the frame; this is how a short frame is dropped
  always_ff @(negedge link_clk_i or posedge frame_sel_n_i) begin
    if (frame_sel_n_i) begin
      shift_r   <= '0;
      bit_cnt_r <= '0;
    end else begin
      shift_r   <= full_word_w[22:0];
      bit_cnt_r <= (bit_cnt_r == ddsc_pkg::BIT_CNT_LAST) ? 5'h00 : bit_cnt_r + 5'h01;
    end
  end

  // completed word and event toggle keep state across frames
  always_ff @(negedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      frame_word_r <= '0;
      frame_tgl_r  <= 1'b0;
    end else if (!frame_sel_n_i && bit_cnt_r == ddsc_pkg::BIT_CNT_LAST) begin
      frame_word_r <= full_word_w;
      frame_tgl_r  <= ~frame_tgl_r;
    end
  end

  // ---------------- crossing to system domain ----------------
  // word is stable for many system cycles after the toggle moves
  logic [2:0] tgl_sync_r;
  logic [2:0] sel_sync_r;
  logic       tgl_seen_r;
  logic       sel_seen_r;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tgl_sync_r <= 3'h0;
      sel_sync_r <= 3'h7;
      tgl_seen_r <= 1'b0;
      sel_seen_r <= 1'b1;
    end else begin
      tgl_sync_r <= {tgl_sync_r[1:0], frame_tgl_r};
      sel_sync_r <= {sel_sync_r[1:0], frame_sel_n_i};
      if (tgl_sync_r[2] == tgl_sync_r[1]) begin
        tgl_seen_r <= tgl_sync_r[2];
      end
      if (sel_sync_r[2] == sel_sync_r[1]) begin
        sel_seen_r <= sel_sync_r[2];
      end
    end
  end

  wire new_frame_w = (tgl_sync_r[2] == tgl_sync_r[1]) && (tgl_sync_r[2] != tgl_seen_r);
  wire sel_rise_w  = (sel_sync_r[2] == sel_sync_r[1]) && sel_sync_r[2] && !sel_seen_r;

  // frame counting per select window tells a dropped frame apart
  logic got_frame_r;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      got_frame_r  <= 1'b0;
      frame_drop_o <= 1'b0;
    end else begin
      frame_drop_o <= sel_rise_w && !got_frame_r && !new_frame_w;
      if (sel_rise_w) begin
        got_frame_r <= 1'b0;
      end else if (new_frame_w) begin
        got_frame_r <= 1'b1;
      end
    end
  end

  // ---------------- frame fifo ----------------
  logic        fifo_out_valid;
  logic [23:0] fifo_out_data;

  // frames are at least 24 link clocks apart, so the fifo never overflows
  ddsc_fifo #(
    .WIDTH (ddsc_pkg::CMD_W),
    .DEPTH (ddsc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (new_frame_w),
    .in_ready_o  (),
    .in_data_i   (frame_word_r),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (1'b1),
    .out_data_o  (fifo_out_data)
  );

  // ---------------- frame decode ----------------
  wire        load_channel_b  = fifo_out_data[ddsc_pkg::POS_LOAD_B];
  wire        load_channel_a  = fifo_out_data[ddsc_pkg::POS_LOAD_A];
  wire        buf_sel_w       = fifo_out_data[ddsc_pkg::POS_BUF_SEL];
  wire        power_mode_high = fifo_out_data[ddsc_pkg::POS_MODE_HIGH];
  wire        power_mode_low  = fifo_out_data[ddsc_pkg::POS_MODE_LOW];
  wire [1:0]  mode_w          = {power_mode_high, power_mode_low};
  wire [15:0] sample_w        = fifo_out_data[15:0];
  // drain side is always ready, so every stored frame is applied once
  wire        apply_w         = fifo_out_valid;
  wire        pd_w            = (mode_w != ddsc_pkg::DDSC_MODE_NORMAL);

  // buffer written this frame, seen by the same-frame load
  logic [15:0] buf_a_r;
  logic [15:0] buf_b_r;
  logic [1:0]  buf_a_mode_r;
  logic [1:0]  buf_b_mode_r;
  wire         wr_a_w = apply_w & !buf_sel_w;
  wire         wr_b_w = apply_w &  buf_sel_w;
  // sample kept unchanged on a power-down write
  wire [15:0]  buf_a_nxt = (wr_a_w && !pd_w) ? sample_w : buf_a_r;
  wire [15:0]  buf_b_nxt = (wr_b_w && !pd_w) ? sample_w : buf_b_r;
  wire [1:0]   buf_a_mode_nxt = wr_a_w ? mode_w : buf_a_mode_r;
  wire [1:0]   buf_b_mode_nxt = wr_b_w ? mode_w : buf_b_mode_r;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      buf_a_r      <= ddsc_pkg::SAMPLE_RESET;
      buf_b_r      <= ddsc_pkg::SAMPLE_RESET;
      buf_a_mode_r <= ddsc_pkg::MODE_RESET;
      buf_b_mode_r <= ddsc_pkg::MODE_RESET;
    end else begin
      buf_a_r      <= buf_a_nxt;
      buf_b_r      <= buf_b_nxt;
      buf_a_mode_r <= buf_a_mode_nxt;
      buf_b_mode_r <= buf_b_mode_nxt;
    end
  end

  // ---------------- channel registers ----------------
  wire load_a_w = apply_w & load_channel_a;
  wire load_b_w = apply_w & load_channel_b;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      chan_a_code_o <= ddsc_pkg::SAMPLE_RESET;
      chan_b_code_o <= ddsc_pkg::SAMPLE_RESET;
      chan_a_mode_o <= ddsc_pkg::MODE_RESET;
      chan_b_mode_o <= ddsc_pkg::MODE_RESET;
    end else begin
      if (load_a_w) begin
        chan_a_code_o <= buf_a_nxt;
        chan_a_mode_o <= buf_a_mode_nxt;
      end
      if (load_b_w) begin
        chan_b_code_o <= buf_b_nxt;
        chan_b_mode_o <= buf_b_mode_nxt;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      frame_done_o <= 1'b0;
    end else begin
      frame_done_o <= apply_w;
    end
  end

  assign buf_a_code_o = buf_a_r;
  assign buf_b_code_o = buf_b_r;
endmodule

//--- testbench/ddsc_port_props.sv
// output checks for the command port
// assumes sys_clk_i free running, link traffic inside frames
`timescale 1ns/100ps
module ddsc_port_props (
  // clock and reset
  input wire logic        sys_clk_i,
  input wire logic        rst_n_i,
  // watched outputs
  input wire logic [15:0] chan_a_code_o,
  input wire logic [1:0]  chan_a_mode_o,
  input wire logic [15:0] chan_b_code_o,
  input wire logic [1:0]  chan_b_mode_o,
  input wire logic [15:0] buf_a_code_o,
  input wire logic [15:0] buf_b_code_o,
  input wire logic        frame_done_o,
  input wire logic        frame_drop_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // done rises on the edge that updates state, so a change is seen with done high
  sequence done_pulse_s;
    frame_done_o ##1 !frame_done_o;
  endsequence
  chan_a_upd_a: assert property (
    $changed(chan_a_code_o) |-> done_pulse_s) else $error("chan a moved outside a frame");
  chan_b_upd_a: assert property (
    $changed(chan_b_code_o) |-> done_pulse_s) else $error("chan b moved outside a frame");
  buf_upd_a: assert property (
    $changed(buf_a_code_o) || $changed(buf_b_code_o) |-> done_pulse_s)
    else $error("buffer moved outside a frame");
  mode_upd_a: assert property (
    $changed(chan_a_mode_o) || $changed(chan_b_mode_o) |-> done_pulse_s)
    else $error("mode moved outside a frame");
  done_pulse_a: assert property (
    frame_done_o |=> !frame_done_o) else $error("done longer than one cycle");
  drop_pulse_a: assert property (
    frame_drop_o |=> !frame_drop_o) else $error("drop longer than one cycle");
  drop_quiet_a: assert property (
    frame_drop_o |-> !frame_done_o && $stable(chan_a_code_o) && $stable(buf_a_code_o))
    else $error("dropped frame changed state");
  reset_zero_a: assert property (
    $rose(rst_n_i) |-> chan_a_code_o == 16'h0000 && chan_b_code_o == 16'h0000
      && chan_a_mode_o == 2'h0 && chan_b_mode_o == 2'h0) else $error("channels not cleared");
endmodule

bind ddsc_port ddsc_port_props u_props (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
  .chan_a_code_o(chan_a_code_o), .chan_a_mode_o(chan_a_mode_o),
  .chan_b_code_o(chan_b_code_o), .chan_b_mode_o(chan_b_mode_o),
  .buf_a_code_o(buf_a_code_o), .buf_b_code_o(buf_b_code_o),
  .frame_done_o(frame_done_o), .frame_drop_o(frame_drop_o)
);

//--- testbench/ddsc_host_model.sv
// serial master model driving the command port
// assumes one device on the link, 125 ns link period
`timescale 1ns/100ps
module ddsc_host_model (
  // serial link
  output logic link_clk_o,
  output logic frame_sel_n_o,
  output logic link_data_o
);
  initial begin
    link_clk_o    = 1'b0;
    frame_sel_n_o = 1'b1;
    link_data_o   = 1'b0;
  end
  // clock idles low; data flips after release so stale bits never look valid
  task automatic send(input logic [23:0] frm, input int nb);
    // one select per device; a shared port would decode one line per converter
    frame_sel_n_o = 1'b0;
    #62.5;
    for (int i = 0; i < nb; i++) begin
      link_clk_o  = 1'b1;
      link_data_o = frm[23-i];
      #62.5;
      link_clk_o = 1'b0;
      if (i < nb - 1) #62.5;
    end
    #5;
    frame_sel_n_o = 1'b1;
    link_data_o   = ~link_data_o;
  endtask
endmodule

//--- testbench/dual_dac_serial_command_port_tb_top.sv
// self-checking bench for the command port
// assumes the host model drives the link, bench owns clock and reset
`timescale 1ns/100ps
module dual_dac_serial_command_port_tb_top;
  logic        sys_clk_i;
  logic        rst_n_i;
  logic        lclk;
  logic        sel_n;
  logic        sdat;
  logic [15:0] a_code;
  logic [15:0] b_code;
  logic [15:0] a_buf;
  logic [15:0] b_buf;
  logic [1:0]  a_mode;
  logic [1:0]  b_mode;
  logic        done;
  logic        drop;
  int          fails = 0;
  int          checks = 0;

  ddsc_host_model host (.link_clk_o(lclk), .frame_sel_n_o(sel_n), .link_data_o(sdat));
  ddsc_port dut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .link_clk_i(lclk), .frame_sel_n_i(sel_n),
    .link_data_i(sdat), .chan_a_code_o(a_code), .chan_a_mode_o(a_mode),
    .chan_b_code_o(b_code), .chan_b_mode_o(b_mode), .buf_a_code_o(a_buf),
    .buf_b_code_o(b_buf), .frame_done_o(done), .frame_drop_o(drop)
  );

  initial sys_clk_i = 1'b0;
  always #5 sys_clk_i = ~sys_clk_i;

  task automatic give_verdict();
    if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // short frames expect a drop pulse, full ones a done pulse
  task automatic wr(input logic lb, input logic la, input logic bs, input logic [1:0] md,
                    input logic [15:0] smp, input int nb);
    int n = 0;
    host.send({2'h0, lb, la, 1'h0, bs, md, smp}, nb);
    while ((nb == 24 ? done : drop) !== 1'b1 && n < 100) begin
      @(negedge sys_clk_i);
      n++;
    end
    if (n == 100) begin
      fails++;
      give_verdict();
    end
  endtask

  task automatic do_reset();
    rst_n_i = 1'b0;
    repeat (12) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    repeat (3) @(negedge sys_clk_i);
  endtask

  initial begin
    do_reset();
    chk(a_code, 16'h0000);
    chk({14'h0, a_mode}, 16'h0000);
    wr(1'h0, 1'h0, 1'h0, 2'h0, 16'h1234, 24);
    chk(a_buf, 16'h1234);
    chk(a_code, 16'h0000);
    wr(1'h1, 1'h1, 1'h1, 2'h0, 16'hABCD, 24);
    chk(a_code, 16'h1234);
    chk(b_code, 16'hABCD);
    chk(b_buf, 16'hABCD);
    wr(1'h0, 1'h1, 1'h0, 2'h0, 16'hFFFF, 13);
    chk(a_code, 16'h1234);
    chk(a_buf, 16'h1234);
    wr(1'h0, 1'h1, 1'h0, 2'h0, 16'h0F0F, 24);
    chk(a_code, 16'h0F0F);
    chk(b_code, 16'hABCD);
    for (int m = 1; m < 4; m++) begin
      wr(1'h0, 1'h1, 1'h0, m[1:0], 16'hFFFF, 24);
      chk({14'h0, a_mode}, {14'h0, m[1:0]});
      chk(a_buf, 16'h0F0F);
    end
    chk({14'h0, b_mode}, 16'h0000);
    wr(1'h0, 1'h1, 1'h0, 2'h0, 16'h8001, 24);
    chk({14'h0, a_mode}, 16'h0000);
    chk(a_code, 16'h8001);
    do_reset();
    chk(b_code, 16'h0000);
    give_verdict();
  end
endmodule
